// file: logic/agop_top.sv
// gain, dc offset loop, sample fifo and ddr lvds / cmos output formatter
// assumes samples arrive on the core clock and the link clock is asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "agop_consts.svh"

// ----------------------------------------
// sample fifo
// ----------------------------------------
module agop_fifo #(
	parameter int WIDTH = 22,
	parameter int DEPTH = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	logic full;
	logic empty;

	assign empty = (wr_ptr == rd_ptr);
	assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	assign o_in_ready = !full;
	assign o_out_valid = !empty;
	assign o_out_data = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge i_core_clk) begin
		if (i_in_valid && !full) begin
			mem[wr_ptr[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (i_in_valid && !full) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (i_out_ready && !empty) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule

// ----------------------------------------
// top
// ----------------------------------------
module agop_top #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_samp_valid,
	output logic o_samp_ready,
	input wire logic [10:0] i_samp_a,
	input wire logic [10:0] i_samp_b,
	input wire logic i_link_clk,
	output logic o_out_clk,
	output logic [5:0] o_lvds_a,
	output logic [5:0] o_lvds_b,
	output logic [10:0] o_cmos_a,
	output logic [10:0] o_cmos_b
);
	localparam int ACC_W = 44;

	logic [31:0] ctrl;
	logic ack;
	logic digital_on;
	logic gain_on;
	logic dc_on;
	logic [3:0] gain_step;
	logic [3:0] tau_code;
	logic [5:0] tau_shift;
	logic signed [ACC_W-1:0] acc_a;
	logic signed [ACC_W-1:0] acc_b;
	logic signed [10:0] est_a;
	logic signed [10:0] est_b;
	logic [21:0] fifo_in;
	logic [21:0] fifo_out;
	logic fifo_valid;
	logic pop;
	logic link_s1;
	logic link_s2;
	logic link_s3;
	logic link_rise;
	logic link_fall;
	logic [21:0] hold;
	agop_pkg::agop_iface_t iface;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// 10^(step/40) in q2.14; last step is exactly 2 so 6 dB halves full scale
	function automatic logic [16:0] gain_factor(input logic [3:0] step);
		logic [16:0] f;
		f = 17'h04000;
		unique case (step)
			4'h0: f = 17'h04000;
			4'h1: f = 17'h043cb;
			4'h2: f = 17'h047cf;
			4'h3: f = 17'h04c10;
			4'h4: f = 17'h05092;
			4'h5: f = 17'h05558;
			4'h6: f = 17'h05a67;
			4'h7: f = 17'h05fc2;
			4'h8: f = 17'h0656f;
			4'h9: f = 17'h06b72;
			4'ha: f = 17'h071cf;
			4'hb: f = 17'h0788e;
			default: f = 17'h08000;
		endcase
		return f;
	endfunction

	function automatic logic [10:0] sat11(input logic signed [31:0] v);
		if (v > 32'sd1023) begin
			return 11'h3ff;
		end else if (v < -32'sd1024) begin
			return 11'h400;
		end
		return v[10:0];
	endfunction

	// offset estimate, clamped to the correctable range
	function automatic logic signed [10:0] estimate(
		input logic signed [ACC_W-1:0] acc, input logic [5:0] sh);
		logic signed [ACC_W-1:0] e;
		e = acc >>> sh;
		if (e > ACC_W'(`AGOP_DC_LIMIT_LSB)) begin
			e = ACC_W'(`AGOP_DC_LIMIT_LSB);
		end else if (e < -ACC_W'(`AGOP_DC_LIMIT_LSB)) begin
			e = -ACC_W'(`AGOP_DC_LIMIT_LSB);
		end
		return e[10:0];
	endfunction

	function automatic logic [10:0] correct_scale(
		input logic signed [10:0] x,
		input logic signed [10:0] est);
		logic signed [31:0] c;
		logic signed [31:0] p;
		c = 32'(x) - (dc_on ? 32'(est) : 32'sd0);
		p = c * $signed({15'h0, gain_on ? gain_factor(gain_step) :
			17'h04000});
		return sat11(p >>> `AGOP_GAIN_FRAC);
	endfunction

	function automatic logic [5:0] pick(input logic [10:0] v,
		input logic odd);
		logic [11:0] w;
		logic [5:0] r;
		w = {1'b0, v};
		r = '0;
		for (int i = 0; i < 6; i++) begin
			r[i] = w[2*i + int'(odd)];
		end
		return r;
	endfunction

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack;

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ack <= 1'b0;
		end else begin
			ack <= (i_avs_read || i_avs_write) && !ack;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl <= `AGOP_CTRL_RESET;
		end else if (i_avs_write && !ack &&
			i_avs_address == `AGOP_REG_CTRL) begin
			for (int i = 0; i < 4; i++) begin
				if (i_avs_byteenable[i]) begin
					ctrl[8*i +: 8] <= i_avs_writedata[8*i +: 8];
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_avs_readdata <= '0;
		end else if (i_avs_read && !ack) begin
			unique case (i_avs_address)
				`AGOP_REG_CTRL: o_avs_readdata <= ctrl;
				`AGOP_REG_EST_A: o_avs_readdata <= 32'(est_a);
				`AGOP_REG_EST_B: o_avs_readdata <= 32'(est_b);
				default: o_avs_readdata <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// control decode
	// ----------------------------------------
	// mode bits gate both
	assign digital_on = ctrl[`AGOP_F_MODE1] && ctrl[`AGOP_F_MODE2];
	assign gain_on = digital_on;
	assign gain_step = (ctrl[`AGOP_F_GAIN_HI:`AGOP_F_GAIN_LO] >
		`AGOP_GAIN_MAX_STEP) ? `AGOP_GAIN_MAX_STEP :
		ctrl[`AGOP_F_GAIN_HI:`AGOP_F_GAIN_LO];
	assign dc_on = digital_on && ctrl[`AGOP_F_DC_ON];
	assign tau_code = (ctrl[`AGOP_F_TAU_HI:`AGOP_F_TAU_LO] >
		`AGOP_TAU_MAX_CODE) ? `AGOP_TAU_MAX_CODE :
		ctrl[`AGOP_F_TAU_HI:`AGOP_F_TAU_LO];
	assign tau_shift = 6'(`AGOP_TAU_BASE_LOG2) + {2'b00, tau_code};
	assign iface = ctrl[`AGOP_F_CMOS] ? agop_pkg::AGOP_CMOS :
		agop_pkg::AGOP_LVDS;

	// ----------------------------------------
	// offset loop
	// ----------------------------------------
	assign est_a = estimate(acc_a, tau_shift);
	assign est_b = estimate(acc_b, tau_shift);

	// first-order loop: acc tracks mean input scaled by 2^shift
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			acc_a <= '0;
			acc_b <= '0;
		end else if (!dc_on) begin
			acc_a <= '0;
			acc_b <= '0;
		end else if (i_samp_valid && !ctrl[`AGOP_F_DC_HOLD]) begin
			acc_a <= acc_a + ACC_W'($signed(i_samp_a)) -
				(acc_a >>> tau_shift);
			acc_b <= acc_b + ACC_W'($signed(i_samp_b)) -
				(acc_b >>> tau_shift);
		end
	end

	// ----------------------------------------
	// datapath into fifo
	// ----------------------------------------
	// correct, scale, saturate
	// a process, not an assign, so control changes alone re-evaluate it
	always_comb begin
		fifo_in = {correct_scale($signed(i_samp_b), est_b),
			correct_scale($signed(i_samp_a), est_a)};
	end

	// a full fifo stalls the converter core
	agop_fifo #(
		.WIDTH(22),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_in_valid(i_samp_valid),
		.o_in_ready(o_samp_ready),
		.i_in_data(fifo_in),
		.o_out_valid(fifo_valid),
		.i_out_ready(pop),
		.o_out_data(fifo_out)
	);

	// ----------------------------------------
	// link clock edges
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			link_s1 <= 1'b0;
			link_s2 <= 1'b0;
			link_s3 <= 1'b0;
		end else begin
			link_s1 <= i_link_clk;
			link_s2 <= link_s1;
			link_s3 <= link_s2;
		end
	end

	assign link_rise = link_s2 && !link_s3;
	assign link_fall = !link_s2 && link_s3;
	assign pop = link_rise;

	// ----------------------------------------
	// output formatter
	// ----------------------------------------
	// an empty fifo repeats the last sample rather than stalling the clock
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			hold <= '0;
		end else if (link_rise && fifo_valid) begin
			hold <= fifo_out;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_out_clk <= 1'b0;
		end else if (link_rise) begin
			o_out_clk <= 1'b0;
		end else if (link_fall) begin
			o_out_clk <= 1'b1;
		end
	end

	// cmos data change while the output clock falls, stable at its rise
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_cmos_a <= '0;
			o_cmos_b <= '0;
		end else if (iface != agop_pkg::AGOP_CMOS) begin
			o_cmos_a <= '0;
			o_cmos_b <= '0;
		end else if (link_rise && fifo_valid) begin
			o_cmos_a <= fifo_out[10:0];
			o_cmos_b <= fifo_out[21:11];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_lvds_a <= '0;
			o_lvds_b <= '0;
		end else if (iface != agop_pkg::AGOP_LVDS) begin
			o_lvds_a <= '0;
			o_lvds_b <= '0;
		end else if (link_rise) begin
			o_lvds_a <= pick(fifo_valid ? fifo_out[10:0] : hold[10:0], 1'b0);
			o_lvds_b <= pick(fifo_valid ? fifo_out[21:11] : hold[21:11],
				1'b0);
		end else if (link_fall) begin
			o_lvds_a <= pick(hold[10:0], 1'b1);
			o_lvds_b <= pick(hold[21:11], 1'b1);
		end
	end
endmodule

`default_nettype wire

// file: logic/agop_consts.svh
// constants of the gain, offset and output path: offsets, fields, timing
// assumes a 25 MHz sampling clock and a 32-bit avalon-mm register slave
`ifndef AGOP_CONSTS_SVH
`define AGOP_CONSTS_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define AGOP_REG_CTRL 4'h0
`define AGOP_REG_EST_A 4'h4
`define AGOP_REG_EST_B 4'h8
`define AGOP_CTRL_RESET 32'h0000_0000

// ----------------------------------------
// control fields
// ----------------------------------------
`define AGOP_F_MODE1 0
`define AGOP_F_MODE2 1
`define AGOP_F_GAIN_LO 4
`define AGOP_F_GAIN_HI 7
`define AGOP_F_DC_ON 8
`define AGOP_F_DC_HOLD 9
`define AGOP_F_CMOS 10
`define AGOP_F_TAU_LO 12
`define AGOP_F_TAU_HI 15

// ----------------------------------------
// gain, offset and loop figures
// ----------------------------------------
`define AGOP_GAIN_MAX_STEP 4'hc
`define AGOP_GAIN_FRAC 14
`define AGOP_TAU_MAX_CODE 4'hb
`define AGOP_TAU_BASE_LOG2 20
`define AGOP_DC_LIMIT_MV 10
`define AGOP_FS_MV 2000
`define AGOP_CODES 2048
`define AGOP_DC_LIMIT_LSB (`AGOP_DC_LIMIT_MV * `AGOP_CODES / `AGOP_FS_MV)

`endif

// file: logic/agop_pkg.sv
// types shared by the gain, offset and output path
// assumes the constants header is included where figures are needed
`default_nettype none
package agop_pkg;
	typedef logic signed [10:0] agop_sample_t;
	typedef enum logic {AGOP_LVDS, AGOP_CMOS} agop_iface_t;
endpackage
`default_nettype wire

// file: test/agop_checker.sv
// port checker for agop_top: bus wait, link timing, output modes
// assumes it is bound to agop_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module agop_checker (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	input wire logic o_samp_ready,
	input wire logic i_link_clk,
	input wire logic o_out_clk,
	input wire logic [5:0] o_lvds_a,
	input wire logic [10:0] o_cmos_a,
	input wire logic [10:0] o_cmos_b
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_b);
	sequence bus_req;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	sequence half_steady;
		$stable(o_out_clk) && $past(o_lvds_a) != 0 && o_lvds_a != 0;
	endsequence
	wait_one_a: assert property (bus_req |=> !o_avs_waitrequest)
		else $error("bus wait longer than one cycle");
	req_wait_a: assert property ($rose(i_avs_read || i_avs_write)
		|-> o_avs_waitrequest) else $error("request not held off");
	idle_nowait_a: assert property (!(i_avs_read || i_avs_write)
		|-> !o_avs_waitrequest) else $error("wait without request");
	link_rise_a: assert property ($rose(i_link_clk) |-> ##[2:4] !o_out_clk)
		else $error("output clock missed low phase");
	link_fall_a: assert property ($fell(i_link_clk) |-> ##[2:4] o_out_clk)
		else $error("output clock missed high phase");
	lvds_half_a: assert property (half_steady |-> $stable(o_lvds_a))
		else $error("pair changed inside a half period");
	cmos_hold_a: assert property (!$fell(o_out_clk) && $past(o_cmos_a) != 0
		&& o_cmos_a != 0 |-> $stable(o_cmos_a)) else $error("cmos moved");
	mode_split_a: assert property (o_cmos_a != 0 || o_cmos_b != 0
		|-> o_lvds_a == 0) else $error("both interfaces driven");
	reset_quiet_a: assert property ($rose(i_rst_b) |-> o_samp_ready
		&& !o_out_clk && o_lvds_a == 0) else $error("outputs busy after reset");
endmodule
`default_nettype wire

// file: test/agop_rx_model.sv
// receiver model: rebuilds both channels from the ddr pairs
// assumes out_clk changes only on core edges, so core sampling is safe
`timescale 1ns/1ps
`default_nettype none
module agop_rx_model (
	input wire logic i_core_clk,
	input wire logic i_out_clk,
	input wire logic [5:0] i_lvds_a,
	input wire logic [5:0] i_lvds_b,
	output logic o_word_valid,
	output logic [10:0] o_word_a,
	output logic [10:0] o_word_b
);
	logic [5:0] ev_a, ev_b, od_a, od_b;
	logic clk_q;
	always @(posedge i_core_clk) begin
		clk_q <= i_out_clk;
		o_word_valid <= clk_q && !i_out_clk;
		if (!i_out_clk) begin
			ev_a <= i_lvds_a;
			ev_b <= i_lvds_b;
		end else begin
			od_a <= i_lvds_a;
			od_b <= i_lvds_b;
		end
		for (int i = 0; i < 11; i++) begin
			o_word_a[i] <= i[0] ? od_a[i/2] : ev_a[i/2];
			o_word_b[i] <= i[0] ? od_b[i/2] : ev_b[i/2];
		end
	end
endmodule
`default_nettype wire

// file: test/test_agop_top.sv
// testbench of agop_top: registers, gain, offset loop, fifo, outputs
// assumes the receiver model and the checker compile first
`timescale 1ns/1ps
`default_nettype none
module test_agop_top;
	logic i_core_clk = 1'b0, i_rst_b = 1'b0, i_link_clk = 1'b0;
	logic i_avs_read = 1'b0, i_avs_write = 1'b0, i_samp_valid = 1'b0;
	logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hf;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
	logic [10:0] i_samp_a = 11'h0, i_samp_b = 11'h0, o_cmos_a, o_cmos_b;
	logic [10:0] rx_a, rx_b;
	logic [5:0] o_lvds_a, o_lvds_b;
	logic o_avs_waitrequest, o_samp_ready, o_out_clk, rx_v;
	int miscompares = 0, num_checks = 0;
	agop_top u_agop_top (.*);
	agop_rx_model u_agop_rx_model (.i_core_clk(i_core_clk),
		.i_out_clk(o_out_clk), .i_lvds_a(o_lvds_a), .i_lvds_b(o_lvds_b),
		.o_word_valid(rx_v), .o_word_a(rx_a), .o_word_b(rx_b));
	always #20 i_core_clk = ~i_core_clk;
	// link clock offset so its edges never meet the core edges
	initial begin
		#7;
		forever #160 i_link_clk = ~i_link_clk;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_core_clk);
		i_avs_write <= w;
		i_avs_read <= !w;
		i_avs_address <= a;
		i_avs_writedata <= d;
		@(posedge i_core_clk);
		while (o_avs_waitrequest !== 1'b0 && n < 20) begin
			@(posedge i_core_clk);
			n++;
		end
		if (o_avs_waitrequest !== 1'b0) begin
			miscompares++;
			test_done;
		end
		rd = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask
	task automatic send(input logic [10:0] a, b);
		int n;
		n = 0;
		@(posedge i_core_clk);
		i_samp_valid <= 1'b1;
		i_samp_a <= a;
		i_samp_b <= b;
		@(posedge i_core_clk);
		while (o_samp_ready !== 1'b1 && n < 300) begin
			@(posedge i_core_clk);
			n++;
		end
		if (o_samp_ready !== 1'b1) begin
			miscompares++;
			test_done;
		end
		i_samp_valid <= 1'b0;
	endtask
	task automatic rxchk(input string what, input logic [10:0] ea, eb);
		int n;
		n = 0;
		while (!(rx_v === 1'b1 && rx_a === ea) && n < 300) begin
			@(negedge i_core_clk);
			n++;
		end
		chk(what, {rx_a, rx_b}, {ea, eb});
		if (n == 300) begin
			test_done;
		end
	endtask
	task automatic t_reset;
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl", rd, 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk("est", rd, 32'h0);
		bus(1'b0, 4'hc, 32'h0);
		chk("unmapped", rd, 32'h0);
	endtask
	task automatic t_gain;
		bus(1'b1, 4'h0, 32'h000000c0);
		send(11'h064, 11'h7fb);
		rxchk("no mode", 11'h064, 11'h7fb);
		bus(1'b1, 4'h0, 32'h00000003);
		send(11'h065, 11'h7fa);
		rxchk("0 dB", 11'h065, 11'h7fa);
		bus(1'b1, 4'h0, 32'h000000c3);
		send(11'h066, 11'h7f9);
		rxchk("6 dB", 11'h0cc, 11'h7f2);
		send(11'h300, 11'h500);
		rxchk("clip", 11'h3ff, 11'h400);
	endtask
	task automatic t_dc;
		logic rdy;
		// mode bits already on, then loop with code 0
		bus(1'b1, 4'h0, 32'h00000103);
		@(posedge i_core_clk);
		i_samp_valid <= 1'b1;
		i_samp_a <= 11'h3ff;
		i_samp_b <= 11'h400;
		repeat (12000) @(posedge i_core_clk);
		// a pop frees one slot for a single cycle, so look twice
		@(negedge i_core_clk);
		rdy = o_samp_ready;
		@(negedge i_core_clk);
		chk("full", rdy & o_samp_ready, 1'b0);
		bus(1'b0, 4'h4, 32'h0);
		chk("est a", rd, 32'h0000000a);
		bus(1'b0, 4'h8, 32'h0);
		chk("est b", rd, 32'hfffffff6);
		bus(1'b1, 4'h0, 32'h00000303);
		i_samp_a <= 11'h000;
		repeat (2000) @(posedge i_core_clk);
		i_samp_valid <= 1'b0;
		bus(1'b0, 4'h4, 32'h0);
		chk("held", rd, 32'h0000000a);
		send(11'h1f4, 11'h000);
		rxchk("corrected", 11'h1ea, 11'h00a);
		bus(1'b1, 4'h0, 32'h00000003);
		bus(1'b0, 4'h4, 32'h0);
		chk("off", rd, 32'h0);
	endtask
	task automatic t_cmos;
		int n;
		n = 0;
		bus(1'b1, 4'h0, 32'h00000403);
		send(11'h12c, 11'h007);
		while (o_cmos_a !== 11'h12c && n < 300) begin
			@(negedge i_core_clk);
			n++;
		end
		chk("cmos", {o_cmos_a, o_cmos_b}, {11'h12c, 11'h007});
		chk("lvds off", o_lvds_a, 6'h00);
		if (n == 300) begin
			test_done;
		end
	endtask
	initial begin
		repeat (3) @(posedge i_core_clk);
		i_rst_b <= 1'b1;
		t_reset;
		t_gain;
		t_dc;
		t_cmos;
		test_done;
	end
endmodule
bind agop_top agop_checker u_agop_checker (.*);
`default_nettype wire
